// ==== irc_consts.svh ====
/*
  Constants for the initial reset controller: register indices, field
  positions, reset values and timing counts.
  Assumes it is included by bare name from the top module and the bench.
*/
`ifndef IRC_CONSTS_SVH
`define IRC_CONSTS_SVH

// Register indices; the byte address on the bus is four times the index.
`define IRC_IDX_WDT_STATUS   18'h05041
`define IRC_IDX_KEY_CONFIG   18'h05209
`define IRC_IDX_EVT_STATUS   18'h05300
`define IRC_IDX_EVT_MASK     18'h05301
`define IRC_IDX_RESET_CAUSE  18'h05302

// Field positions.
`define IRC_WDT_ACTION_BIT   1
`define IRC_KEY_SEL_LSB      0
`define IRC_KEY_SEL_MSB      1
`define IRC_EVT_PIN_BIT      0
`define IRC_EVT_KEY_BIT      1
`define IRC_EVT_WDT_BIT      2
`define IRC_EVT_NMI_BIT      3

// Key-entry select encodings.
`define IRC_KEY_SEL_OFF      2'h0
`define IRC_KEY_SEL_TWO      2'h1
`define IRC_KEY_SEL_THREE    2'h2
`define IRC_KEY_SEL_FOUR     2'h3

// Reset values.
`define IRC_KEY_SEL_RESET    2'h0
`define IRC_WDT_ACTION_RESET 1'b0
`define IRC_EVT_MASK_RESET   4'h0
`define IRC_RESET_VECTOR     24'h008000

// Bus responses.
`define IRC_RESP_OKAY        2'h0
`define IRC_RESP_SLVERR      2'h2

// Timing: the wait is 1024 main-oscillator periods; the clock is that oscillator.
`define IRC_CLK_PERIOD_NS    50
`define IRC_STAB_OSC_PERIODS 1024
`define IRC_STAB_TIME_NS     (`IRC_STAB_OSC_PERIODS * `IRC_CLK_PERIOD_NS)
`define IRC_STAB_CYCLES      ((`IRC_STAB_TIME_NS + `IRC_CLK_PERIOD_NS - 1) / `IRC_CLK_PERIOD_NS)

`endif

// ==== irc_pkg.sv ====
/*
  Types for the initial reset controller.
  Assumes irc_consts.svh is on the include path.
*/
package irc_pkg;

  typedef enum logic [1:0] {
    IRC_RESET_HOLD,
    IRC_STAB_WAIT,
    IRC_VECTOR_FETCH,
    IRC_RUN
  } irc_state_t;

  typedef logic [3:0] irc_evt_t;

endpackage

// ==== irc_top.sv ====
/*
  Initial reset controller: combines the external reset pin, the key-entry
  reset and the watchdog overflow into one internal reset, waits for the
  oscillator to settle and releases the CPU into its reset vector fetch.
  Assumes all inputs but the pin and keys are synchronous to clock, which is the main oscillator,
  and an AXI4-Lite master with 32-bit data on the register side.
*/
// Functional notes
// R1 - Pin, key-entry or watchdog source resets both CPU and peripherals.
// R2 - On release the CPU fetches its start address from vector entry zero.
// R3 - Low external pin holds reset; returning high ends it.
// R4 - Undriven external pin is pulled up and reads as deasserted.
// R5 - All selected key inputs low together trigger a reset.
// R6 - Select field 3, 2, 1 picks four, three, two inputs; 0 disables.
// R7 - Key-entry detection is ignored during sleep.
// R8 - Any initial reset clears the key-entry select to disabled.
// R9 - Watchdog overflows unless software restarts it every four seconds.
// R10 - Overflow resets when action bit is one, raises NMI when zero.
// R11 - Watchdog action returns to NMI on every initial reset.
// R12 - CPU stays held for 1024 oscillator periods after reset ends.
// R13 - After release the CPU runs on the main oscillator clock.
// R14 - Reset clears CPU general registers, status register and stack pointer.
// R15 - Reset leaves internal RAM and display memory untouched.
// R16 - Reset returns peripheral registers to their defaults; here only key select and watchdog action are reset, not evt_mask.
// R17 - The reset vector lies at the table base 0x8000.
// R18 - Pin and keys are synchronised; any new reset restarts the wait.
`timescale 1ns/10ps
`include "irc_consts.svh"

module irc_top #(
  parameter int STAB_CYCLES = `IRC_STAB_CYCLES
) (
  input  wire  logic                 clock,
  input  wire  logic                 rst,
  input  wire  logic                 reset_pin_n_level,
  input  wire  logic                 reset_pin_driven,
  input  wire  logic [3:0]           key_inputs,
  input  wire  logic                 sleep_mode,
  input  wire  logic                 wdt_overflow,
  output logic                       core_reset,
  output logic                       core_state_clear,
  output logic                       periph_reset,
  output logic                       mem_clear,
  output logic                       main_osc_select,
  output logic                       vector_fetch,
  output logic [23:0]                reset_vector_addr,
  output logic                       nmi_req,
  output irc_pkg::irc_state_t        boot_state,
  output logic                       irq,
  input  wire  logic [19:0]          s_axi_awaddr,
  input  wire  logic                 s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire  logic [31:0]          s_axi_wdata,
  input  wire  logic [3:0]           s_axi_wstrb,
  input  wire  logic                 s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire  logic                 s_axi_bready,
  input  wire  logic [19:0]          s_axi_araddr,
  input  wire  logic                 s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire  logic                 s_axi_rready
);
  import irc_pkg::*;

  localparam logic [10:0] STAB_LAST = 11'(STAB_CYCLES - 1);

  logic                pin_level;
  logic [1:0]          pin_sync;
  logic [3:0]          key_meta;
  logic [3:0]          key_sync;
  logic [3:0]          key_used;
  logic                pin_req;
  logic                key_req;
  logic                wdt_req;
  logic                nmi_hit;
  logic                reset_src;
  logic [10:0]         stab_count;
  irc_state_t          state;
  irc_state_t          next_state;
  logic [1:0]          key_reset_select;
  logic                wdt_overflow_action;
  irc_evt_t            evt_status;
  irc_evt_t            evt_mask;
  irc_evt_t            evt_set;
  irc_evt_t            reset_cause;
  logic                aw_held;
  logic                w_held;
  logic [17:0]         aw_index;
  logic [31:0]         w_data;
  logic                w_lane0;
  logic                wr_fire;
  logic                wr_hit;
  logic [17:0]         ar_index;
  logic                rd_fire;
  logic                stat_read;

  //////////////////////////////////////////////////////////////////////////
  // Input synchronisers.

  // The pull-up makes a floating pin read high. [R4]
  assign pin_level = reset_pin_driven ? reset_pin_n_level : 1'b1;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_sync <= 2'h3;
    end else begin
      pin_sync <= {pin_sync[0], pin_level}; // [R18]
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_key_sync
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          key_meta[gi] <= 1'b1;
          key_sync[gi] <= 1'b1;
        end else begin
          key_meta[gi] <= key_inputs[gi]; // [R18]
          key_sync[gi] <= key_meta[gi];
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // Reset source combination.

  always_comb begin
    case (key_reset_select)
      `IRC_KEY_SEL_FOUR:  key_used = 4'hf; // [R6]
      `IRC_KEY_SEL_THREE: key_used = 4'h7; // [R6]
      `IRC_KEY_SEL_TWO:   key_used = 4'h3; // [R6]
      default:            key_used = 4'h0; // [R6]
    endcase
  end

  assign pin_req = ~pin_sync[1]; // [R3]
  // Sleep stops the key logic, so the keys cannot wake the part into reset. [R7]
  assign key_req = (key_used != 4'h0) && ((key_sync & key_used) == 4'h0) && !sleep_mode; // [R5]
  assign wdt_req = wdt_overflow && wdt_overflow_action; // [R10] [R9]
  assign nmi_hit = wdt_overflow && !wdt_overflow_action; // [R10]
  assign reset_src = pin_req || key_req || wdt_req; // [R1]

  //////////////////////////////////////////////////////////////////////////
  // Release sequencer.

  always_comb begin
    next_state = state;
    case (state)
      IRC_RESET_HOLD: begin
        if (!reset_src) begin
          next_state = IRC_STAB_WAIT;
        end
      end
      IRC_STAB_WAIT: begin
        if (stab_count == STAB_LAST) begin
          next_state = IRC_VECTOR_FETCH; // [R12]
        end
      end
      IRC_VECTOR_FETCH: begin
        next_state = IRC_RUN; // [R2]
      end
      default: begin
        next_state = IRC_RUN;
      end
    endcase
    if (reset_src) begin
      next_state = IRC_RESET_HOLD; // [R18] [R1]
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= IRC_RESET_HOLD;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stab_count <= 11'h000;
    end else if (next_state == IRC_STAB_WAIT && state == IRC_STAB_WAIT) begin
      stab_count <= stab_count + 11'h001; // [R12]
    end else begin
      stab_count <= 11'h000; // [R18]
    end
  end

  // Outputs except nmi_req are registered from the next state so they line up with state.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      core_reset        <= 1'b1;
      core_state_clear  <= 1'b1;
      periph_reset      <= 1'b1;
      vector_fetch      <= 1'b0;
      nmi_req           <= 1'b0;
    end else begin
      core_reset        <= (next_state == IRC_RESET_HOLD) || (next_state == IRC_STAB_WAIT); // [R12]
      core_state_clear  <= (next_state == IRC_RESET_HOLD); // [R14]
      periph_reset      <= (next_state == IRC_RESET_HOLD); // [R16] [R1]
      vector_fetch      <= (next_state == IRC_VECTOR_FETCH); // [R2]
      nmi_req           <= nmi_hit && !reset_src; // [R10]
    end
  end

  // Memories keep their contents; there is deliberately no clear path. [R15]
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mem_clear         <= 1'b0;
      main_osc_select   <= 1'b1;
      reset_vector_addr <= `IRC_RESET_VECTOR;
    end else begin
      mem_clear         <= 1'b0; // [R15]
      main_osc_select   <= 1'b1; // [R13]
      reset_vector_addr <= `IRC_RESET_VECTOR; // [R17]
    end
  end

  assign boot_state = state;

  //////////////////////////////////////////////////////////////////////////
  // Register slave, write path.

  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      aw_held  <= 1'b0;
      aw_index <= 18'h00000;
    end else if (s_axi_awvalid && !aw_held) begin
      aw_held  <= 1'b1;
      aw_index <= s_axi_awaddr[19:2];
    end else if (wr_fire) begin
      aw_held  <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      w_held  <= 1'b0;
      w_data  <= 32'h00000000;
      w_lane0 <= 1'b0;
    end else if (s_axi_wvalid && !w_held) begin
      w_held  <= 1'b1;
      w_data  <= s_axi_wdata;
      w_lane0 <= s_axi_wstrb[0];
    end else if (wr_fire) begin
      w_held  <= 1'b0;
    end
  end

  always_comb begin
    if (aw_index == `IRC_IDX_WDT_STATUS) begin
      wr_hit = 1'b1;
    end else if (aw_index == `IRC_IDX_KEY_CONFIG) begin
      wr_hit = 1'b1;
    end else if (aw_index == `IRC_IDX_EVT_STATUS) begin
      wr_hit = 1'b1;
    end else if (aw_index == `IRC_IDX_EVT_MASK) begin
      wr_hit = 1'b1;
    end else if (aw_index == `IRC_IDX_RESET_CAUSE) begin
      wr_hit = 1'b1;
    end else begin
      wr_hit = 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `IRC_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? `IRC_RESP_OKAY : `IRC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Key select and watchdog action are cleared while reset is held; writes to them then are lost.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      key_reset_select    <= `IRC_KEY_SEL_RESET;
      wdt_overflow_action <= `IRC_WDT_ACTION_RESET;
    end else if (state == IRC_RESET_HOLD) begin
      key_reset_select    <= `IRC_KEY_SEL_RESET; // [R8] [R16]
      wdt_overflow_action <= `IRC_WDT_ACTION_RESET; // [R11]
    end else if (wr_fire && w_lane0) begin
      if (aw_index == `IRC_IDX_KEY_CONFIG) begin
        key_reset_select <= w_data[`IRC_KEY_SEL_MSB:`IRC_KEY_SEL_LSB]; // [R6]
      end else if (aw_index == `IRC_IDX_WDT_STATUS) begin
        wdt_overflow_action <= w_data[`IRC_WDT_ACTION_BIT]; // [R10]
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      evt_mask <= `IRC_EVT_MASK_RESET;
    end else if (wr_fire && w_lane0 && aw_index == `IRC_IDX_EVT_MASK) begin
      evt_mask <= w_data[3:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Event flags and interrupt.

  always_comb begin
    evt_set = 4'h0;
    evt_set[`IRC_EVT_PIN_BIT] = pin_req;
    evt_set[`IRC_EVT_KEY_BIT] = key_req;
    evt_set[`IRC_EVT_WDT_BIT] = wdt_req;
    evt_set[`IRC_EVT_NMI_BIT] = nmi_hit;
  end

  assign stat_read = rd_fire && (s_axi_araddr[19:2] == `IRC_IDX_EVT_STATUS);

  // A new event in the reading cycle survives the clear.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      evt_status <= 4'h0;
    end else if (stat_read) begin
      evt_status <= evt_set;
    end else begin
      evt_status <= evt_status | evt_set;
    end
  end

  // The last cause is kept until the next reset, for software to inspect.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reset_cause <= 4'h0;
    end else if (reset_src) begin
      reset_cause <= {1'b0, evt_set[2:0]};
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(evt_status & evt_mask);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Register slave, read path.

  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire = s_axi_arvalid && !s_axi_rvalid;
  assign ar_index = s_axi_araddr[19:2];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `IRC_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `IRC_RESP_OKAY;
      if (ar_index == `IRC_IDX_WDT_STATUS) begin
        s_axi_rdata <= {30'h0, wdt_overflow_action, 1'b0};
      end else if (ar_index == `IRC_IDX_KEY_CONFIG) begin
        s_axi_rdata <= {30'h0, key_reset_select};
      end else if (ar_index == `IRC_IDX_EVT_STATUS) begin
        s_axi_rdata <= {28'h0, evt_status};
      end else if (ar_index == `IRC_IDX_EVT_MASK) begin
        s_axi_rdata <= {28'h0, evt_mask};
      end else if (ar_index == `IRC_IDX_RESET_CAUSE) begin
        s_axi_rdata <= {28'h0, reset_cause};
      end else begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `IRC_RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ==== irc_sva.sv ====
/*
  Checker for the initial reset controller, bound to irc_top.
  Assumes one clock domain and the asynchronous active-high rst.
*/
`timescale 1ns/10ps
module irc_sva #(
  parameter int STAB_CYCLES = 1024
) (
  input wire logic                clock,
  input wire logic                rst,
  input wire logic                reset_pin_n_level,
  input wire logic                reset_pin_driven,
  input wire logic                wdt_overflow,
  input wire logic                core_reset,
  input wire logic                core_state_clear,
  input wire logic                periph_reset,
  input wire logic                mem_clear,
  input wire logic                main_osc_select,
  input wire logic                vector_fetch,
  input wire logic [23:0]         reset_vector_addr,
  input wire logic                nmi_req,
  input wire irc_pkg::irc_state_t boot_state
);
  import irc_pkg::*;
  ////////////////////////////////////////////////////////////////////////////////
  int stab_cnt;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) stab_cnt <= 0;
    else if (boot_state == IRC_STAB_WAIT) stab_cnt <= stab_cnt + 1;
    else stab_cnt <= 0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  chk_vector_addr: assert property (reset_vector_addr == 24'h008000)
    else $error("reset vector address wrong");
  chk_mem_kept: assert property (!mem_clear)
    else $error("memory clear asserted");
  chk_osc_select: assert property (main_osc_select)
    else $error("main oscillator not selected");
  chk_clear_pair: assert property (core_state_clear == periph_reset)
    else $error("core clear and peripheral reset differ");
  chk_hold_core: assert property (periph_reset |-> core_reset)
    else $error("core released during reset");
  chk_pin_hold: assert property ((reset_pin_driven && !reset_pin_n_level)[*4] |-> periph_reset)
    else $error("low pin did not reset");
  chk_stab_count: assert property (boot_state == IRC_VECTOR_FETCH |-> stab_cnt == STAB_CYCLES)
    else $error("stabilisation wait length wrong");
  chk_wait_held: assert property (boot_state == IRC_STAB_WAIT |-> core_reset && !vector_fetch)
    else $error("core not held in wait");
  chk_fetch_pulse: assert property (vector_fetch |-> !core_reset ##1 (!vector_fetch && boot_state == IRC_RUN))
    else $error("vector fetch not one pulse into run");
  chk_nmi_cause: assert property (nmi_req |-> $past(wdt_overflow) && !periph_reset)
    else $error("nmi without overflow");
endmodule

bind irc_top irc_sva #(.STAB_CYCLES(STAB_CYCLES)) irc_sva_i (.clock, .rst, .reset_pin_n_level,
  .reset_pin_driven, .wdt_overflow, .core_reset, .core_state_clear, .periph_reset, .mem_clear,
  .main_osc_select, .vector_fetch, .reset_vector_addr, .nmi_req, .boot_state);

// ==== irc_partner.sv ====
/*
  Model of the external reset switch and the key switches.
  Assumes the bench commands it right after rising clock edges.
*/
`timescale 1ns/10ps
module irc_partner (
  input  wire logic       clock,
  input  wire logic       hold_low,
  input  wire logic [3:0] keys_n,
  output logic            reset_pin_n_level,
  output logic            reset_pin_driven,
  output logic [3:0]      key_inputs
);
  // A released pin toggles, so only the pull-up can make it read high.
  initial begin
    reset_pin_n_level = 1'h1;
    reset_pin_driven = 1'h0;
  end
  always @(posedge clock) begin
    reset_pin_driven <= hold_low;
    reset_pin_n_level <= hold_low ? 1'h0 : ~reset_pin_n_level;
  end
  assign key_inputs = keys_n;
endmodule

// ==== tb_top.sv ====
/*
  Testbench for irc_top: register tasks over AXI4-Lite and reset scenarios.
  Assumes irc_consts.svh on the include path and a shortened wait of 8.
*/
`timescale 1ns/10ps
`include "irc_consts.svh"
module tb_top;
  import irc_pkg::*;
  localparam logic [19:0] A_WDT = {`IRC_IDX_WDT_STATUS, 2'h0};
  localparam logic [19:0] A_KEY = {`IRC_IDX_KEY_CONFIG, 2'h0};
  localparam logic [19:0] A_STS = {`IRC_IDX_EVT_STATUS, 2'h0};
  localparam logic [19:0] A_MSK = {`IRC_IDX_EVT_MASK, 2'h0};
  localparam logic [19:0] A_CAU = {`IRC_IDX_RESET_CAUSE, 2'h0};
  logic        clock, rst, hold_low, sleep_mode, wdt_overflow, irq, periph_reset, nmi_req;
  logic        reset_pin_n_level, reset_pin_driven;
  logic [3:0]  keys_n, key_inputs;
  irc_state_t  boot_state;
  logic [19:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int          errors, n_checks;
  ////////////////////////////////////////////////////////////////////////////////
  irc_partner irc_partner_i (.clock, .hold_low, .keys_n, .reset_pin_n_level,
    .reset_pin_driven, .key_inputs);
  irc_top #(.STAB_CYCLES(8)) irc_top_i (.clock, .rst, .reset_pin_n_level, .reset_pin_driven,
    .key_inputs, .sleep_mode, .wdt_overflow, .core_reset(), .core_state_clear(), .periph_reset,
    .mem_clear(), .main_osc_select(), .vector_fetch(), .reset_vector_addr(), .nmi_req,
    .boot_state, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'h0;
    forever #25 clock = ~clock;
  end
  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Waits on 0 reset held, 1 boot done, 2 nmi pulse; a missed bound ends the run.
  task automatic wt(input int w, input int n);
    for (int k = 0; k < n; k++) begin
      @(negedge clock);
      if ((w == 0 && periph_reset === 1'h1) || (w == 1 && boot_state === IRC_RUN)
          || (w == 2 && nmi_req === 1'h1)) return;
    end
    chk($sformatf("wait %0d", w), 32'h1, 32'h0);
    finish_test();
  endtask
  task automatic wr(input logic [19:0] a, input logic [31:0] d);
    logic ta, tw;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (int k = 0; k < 50; k++) begin
      @(negedge clock);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      if (s_axi_bvalid === 1'h1) begin
        chk("bresp", 32'(`IRC_RESP_OKAY), 32'(s_axi_bresp));
        @(posedge clock) s_axi_bready <= 1'h0;
        return;
      end
      @(posedge clock);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
    end
    chk("write answer", 32'h1, 32'h0);
    finish_test();
  endtask
  task automatic rd(input logic [19:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ta;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (int k = 0; k < 50; k++) begin
      @(negedge clock);
      ta = s_axi_arvalid && s_axi_arready;
      if (s_axi_rvalid === 1'h1) begin
        chk($sformatf("rdata %h", a), d, s_axi_rdata);
        chk("rresp", 32'(r), 32'(s_axi_rresp));
        @(posedge clock) s_axi_rready <= 1'h0;
        return;
      end
      @(posedge clock);
      if (ta) s_axi_arvalid <= 1'h0;
    end
    chk("read answer", 32'h1, 32'h0);
    finish_test();
  endtask
  task automatic pulse_wdt;
    @(posedge clock) wdt_overflow <= 1'h1;
    @(posedge clock) wdt_overflow <= 1'h0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clock);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [3:0] pat;
    {rst, hold_low, sleep_mode, wdt_overflow, keys_n} = {4'h8, 4'hf};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 72'h0;
    repeat (6) @(posedge clock);
    rst <= 1'h0;
    wt(1, 40);
    rd(A_KEY, 32'h0, `IRC_RESP_OKAY);
    rd(A_WDT, 32'h0, `IRC_RESP_OKAY);
    rd(A_MSK, 32'h0, `IRC_RESP_OKAY);
    rd(20'h00010, 32'h0, `IRC_RESP_SLVERR);
    @(posedge clock) keys_n <= 4'h0;
    idle(8);
    chk("keys unselected", 32'h0, 32'(periph_reset));
    @(posedge clock) keys_n <= 4'hf;
    idle(2);
    for (int s = 1; s < 4; s++) begin
      pat = 4'(4'hf << (s + 1));
      wr(A_KEY, 32'(s));
      @(posedge clock) keys_n <= pat | 4'h1;
      idle(8);
      chk("keys partial", 32'h0, 32'(periph_reset));
      @(posedge clock) {sleep_mode, keys_n} <= {1'h1, pat};
      idle(8);
      chk("keys in sleep", 32'h0, 32'(periph_reset));
      @(posedge clock) sleep_mode <= 1'h0;
      wt(0, 8);
      @(posedge clock) keys_n <= 4'hf;
      wt(1, 40);
      rd(A_KEY, 32'h0, `IRC_RESP_OKAY);
    end
    @(posedge clock) hold_low <= 1'h1;
    wt(0, 8);
    idle(4);
    @(posedge clock) hold_low <= 1'h0;
    wt(1, 40);
    rd(A_STS, 32'h3, `IRC_RESP_OKAY);
    rd(A_CAU, 32'h1, `IRC_RESP_OKAY);
    wr(A_MSK, 32'h8);
    pulse_wdt();
    wt(2, 4);
    idle(2);
    chk("irq raised", 32'h1, 32'(irq));
    chk("no reset on nmi", 32'h0, 32'(periph_reset));
    rd(A_STS, 32'h8, `IRC_RESP_OKAY);
    idle(2);
    chk("irq cleared", 32'h0, 32'(irq));
    wr(A_MSK, 32'h0);
    pulse_wdt();
    idle(4);
    chk("irq masked", 32'h0, 32'(irq));
    rd(A_STS, 32'h8, `IRC_RESP_OKAY);
    wr(A_WDT, 32'h2);
    rd(A_WDT, 32'h2, `IRC_RESP_OKAY);
    pulse_wdt();
    wt(0, 4);
    wt(1, 40);
    rd(A_WDT, 32'h0, `IRC_RESP_OKAY);
    rd(A_CAU, 32'h4, `IRC_RESP_OKAY);
    finish_test();
  end
endmodule
